// ---- shared/nfrx_pkg.sv ----
// package: register map, field layout and symbol types of the NFC-A receive/anticollision bank
//Behaviour
//- parity setting 1 means each received byte carries a parity bit; 0 none.
//- start-of-frame setting 1 requires a start symbol before frame data; 0 not.
//- CRC mode 1 treats last 16 bits as CRC, checks it, updates result.
//- final-part register holds last four identifier bytes, lowest byte sent last.
//- second-last part register used only for 7- or 10-byte identifiers.
//- third-last part register used only for 10-byte identifiers.
//- identifier length field: 0 four bytes, 1 seven bytes, 2 ten bytes.
//- collision engine answers with cascade levels sized by identifier length.
//- bit-frame pattern sits in SENS_RES byte 1 bits b5:b1, reset 1.
//- platform configuration nibble sent as SENS_RES byte 2 bits b4:b1.
package nfrx_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_RX_FRAME_CONFIG = 12'h520;
  localparam logic [11:0] OFS_RX_FRAME_SIZE = 12'h524;
  localparam logic [11:0] OFS_TAG_ID_FINAL = 12'h590;
  localparam logic [11:0] OFS_TAG_ID_SECOND = 12'h594;
  localparam logic [11:0] OFS_TAG_ID_THIRD = 12'h598;
  localparam logic [11:0] OFS_COLL_CTRL = 12'h59C;
  localparam logic [11:0] OFS_SENSE_RESP = 12'h5A0;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h600;
  localparam logic [11:0] OFS_EVENT_MASK = 12'h604;
  localparam logic [11:0] OFS_RX_RESULT = 12'h608;

  // rx_frame_config fields
  localparam int CFG_PARITY_BIT = 0;
  localparam int CFG_SOF_BIT = 2;
  localparam int CFG_CRC_BIT = 4;
  localparam logic [31:0] RST_RX_FRAME_CONFIG = 32'h0000_0015;
  // rx_frame_size fields
  localparam int SIZE_BITS_LSB = 0;
  localparam int SIZE_BYTES_LSB = 3;
  // tag id / collision control / sense response
  localparam logic [31:0] RST_TAG_ID_FINAL = 32'h0000_6363;
  localparam logic [31:0] RST_TAG_ID_OTHER = 32'h0000_0000;
  localparam logic [31:0] RST_COLL_CTRL = 32'h0000_0002;
  localparam logic [31:0] COLL_CTRL_MASK = 32'h0000_0003;
  localparam logic [31:0] RST_SENSE_RESP = 32'h0000_0001;
  localparam logic [31:0] SENSE_RESP_MASK = 32'h0000_FFFF;
  localparam int SR_PATTERN_LSB = 0;
  localparam int SR_IDLEN_LSB = 6;
  localparam int SR_PLATFORM_LSB = 8;
  localparam logic [7:0] CASCADE_TAG = 8'h88;
  // crc: reflected polynomial and preset; a good frame leaves zero residue
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_PRESET = 16'h6363;
  localparam logic [2:0] MIN_BITS_NO_BYTE = 3'h7;
  // event bits
  localparam int EV_FRAME_DONE = 0;
  localparam int EV_CRC_ERR = 1;
  localparam int EV_PARITY_ERR = 2;
  localparam int EV_INVALID = 3;
  localparam int EV_FRAMING_ERR = 4;
  localparam int EV_W = 5;

  typedef enum logic [1:0] {
    NFRX_ID_LEN_FOUR = 2'h0,
    NFRX_ID_LEN_SEVEN = 2'h1,
    NFRX_ID_LEN_TEN = 2'h2
  } nfrx_idlen_e;

  typedef enum logic [1:0] {
    NFRX_SYM_START = 2'h0,
    NFRX_SYM_DATA = 2'h1,
    NFRX_SYM_END = 2'h2
  } nfrx_sym_e;

  typedef struct packed {
    logic valid;
    nfrx_sym_e kind;
    logic bit_val;
  } nfrx_sym_s;

  typedef struct packed {
    logic valid;
    logic final_level;
    logic [31:0] data;
    logic [7:0] check;
  } nfrx_level_s;
endpackage

// ---- logic/nfrx_bank.sv ----
// module: NFC-A receive framing, frame-size report and anticollision settings bank
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module nfrx_bank (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [nfrx_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire nfrx_pkg::nfrx_sym_s rx_sym_i,
  input wire logic [1:0] ac_level_i,
  output nfrx_pkg::nfrx_level_s ac_level_o,
  output logic [15:0] sense_res_o,
  output logic [1:0] coll_ctrl_o,
  output logic irq_o
);
  import nfrx_pkg::*;

  typedef enum logic {NFRX_IDLE, NFRX_BITS} nfrx_state_e;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = fb ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
  endfunction

  function automatic logic [7:0] xor4(input logic [31:0] w);
    xor4 = w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
  endfunction

  // ---------------- registers ----------------
  logic [31:0] rx_frame_config_reg, rx_frame_config_next;
  logic [11:0] rx_frame_size_reg, rx_frame_size_next;
  logic [31:0] tag_id_final_part_reg, tag_id_final_part_next;
  logic [31:0] tag_id_second_final_part_reg, tag_id_second_final_part_next;
  logic [31:0] tag_id_third_final_part_reg, tag_id_third_final_part_next;
  logic [31:0] collision_resolve_ctrl_reg, collision_resolve_ctrl_next;
  logic [31:0] sense_response_cfg_reg, sense_response_cfg_next;
  logic [EV_W-1:0] status_reg, status_next;
  logic [EV_W-1:0] mask_reg, mask_next;
  logic [1:0] rx_result_reg, rx_result_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [EV_W-1:0] ev_set;

  logic parity_on, sof_on, crc_on;
  assign parity_on = rx_frame_config_reg[CFG_PARITY_BIT];
  assign sof_on = rx_frame_config_reg[CFG_SOF_BIT];
  assign crc_on = rx_frame_config_reg[CFG_CRC_BIT];

  // ---------------- receive framing ----------------
  nfrx_state_e state_reg, state_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [8:0] byte_cnt_reg, byte_cnt_next;
  logic par_wait_reg, par_wait_next;
  logic par_acc_reg, par_acc_next;
  logic par_bad_reg, par_bad_next;
  logic [15:0] crc_reg, crc_next;
  logic frame_end, frame_invalid, crc_good;

  always_comb begin
    logic take_bit;
    take_bit = 1'b0;
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    par_wait_next = par_wait_reg;
    par_acc_next = par_acc_reg;
    par_bad_next = par_bad_reg;
    crc_next = crc_reg;
    frame_end = 1'b0;
    ev_set = '0;
    if (rx_sym_i.valid) begin
      unique case (state_reg)
        NFRX_IDLE: begin
          bit_cnt_next = '0;
          byte_cnt_next = '0;
          par_wait_next = 1'b0;
          par_acc_next = 1'b0;
          par_bad_next = 1'b0;
          crc_next = CRC_PRESET;
          if (rx_sym_i.kind == NFRX_SYM_START) begin
            state_next = NFRX_BITS;
          end else if (rx_sym_i.kind == NFRX_SYM_DATA) begin
            if (sof_on) begin
              ev_set[EV_FRAMING_ERR] = 1'b1;
            end else begin
              // no start symbol expected: first data bit opens the frame
              state_next = NFRX_BITS;
              bit_cnt_next = 3'h1;
              par_acc_next = rx_sym_i.bit_val;
              crc_next = crc_step(CRC_PRESET, rx_sym_i.bit_val);
            end
          end
        end
        NFRX_BITS: begin
          if (rx_sym_i.kind == NFRX_SYM_START) begin
            // a second start symbol breaks the frame; restart cleanly
            ev_set[EV_FRAMING_ERR] = 1'b1;
            state_next = NFRX_IDLE;
          end else if (rx_sym_i.kind == NFRX_SYM_END) begin
            frame_end = 1'b1;
            state_next = NFRX_IDLE;
          end else if (par_wait_reg) begin
            // parity bits are checked, never counted nor fed to the crc
            par_wait_next = 1'b0;
            par_acc_next = 1'b0;
            if (!(par_acc_reg ^ rx_sym_i.bit_val)) begin
              par_bad_next = 1'b1;
            end
          end else begin
            take_bit = 1'b1;
          end
        end
      endcase
    end
    if (take_bit) begin
      crc_next = crc_step(crc_reg, rx_sym_i.bit_val);
      par_acc_next = par_acc_reg ^ rx_sym_i.bit_val;
      if (bit_cnt_reg == 3'h7) begin
        bit_cnt_next = '0;
        byte_cnt_next = byte_cnt_reg + 9'h1;
        par_wait_next = parity_on;
      end else begin
        bit_cnt_next = bit_cnt_reg + 3'h1;
      end
    end
  end

  assign frame_invalid = (byte_cnt_reg == 9'h0) && (bit_cnt_reg < MIN_BITS_NO_BYTE);
  assign crc_good = (crc_reg == 16'h0000) && (byte_cnt_reg >= 9'h2) && (bit_cnt_reg == 3'h0);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= NFRX_IDLE;
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      par_wait_reg <= 1'b0;
      par_acc_reg <= 1'b0;
      par_bad_reg <= 1'b0;
      crc_reg <= CRC_PRESET;
    end else if (ce_i) begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      par_wait_reg <= par_wait_next;
      par_acc_reg <= par_acc_next;
      par_bad_reg <= par_bad_next;
      crc_reg <= crc_next;
    end
  end

  // ---------------- register file ----------------
  logic [EV_W-1:0] frame_ev;
  always_comb begin
    frame_ev = '0;
    if (frame_end) begin
      if (frame_invalid) begin
        frame_ev[EV_INVALID] = 1'b1;
      end else begin
        frame_ev[EV_FRAME_DONE] = 1'b1;
        frame_ev[EV_CRC_ERR] = crc_on && !crc_good;
        frame_ev[EV_PARITY_ERR] = par_bad_reg;
      end
    end
  end

  always_comb begin
    rx_frame_config_next = rx_frame_config_reg;
    rx_frame_size_next = rx_frame_size_reg;
    tag_id_final_part_next = tag_id_final_part_reg;
    tag_id_second_final_part_next = tag_id_second_final_part_reg;
    tag_id_third_final_part_next = tag_id_third_final_part_reg;
    collision_resolve_ctrl_next = collision_resolve_ctrl_reg;
    sense_response_cfg_next = sense_response_cfg_reg;
    mask_next = mask_reg;
    rx_result_next = rx_result_reg;
    status_next = status_reg;
    rdata_next = '0;
    if (wr_i) begin
      unique case (addr_i)
        OFS_RX_FRAME_CONFIG: rx_frame_config_next = wdata_i & RST_RX_FRAME_CONFIG;
        OFS_TAG_ID_FINAL: tag_id_final_part_next = wdata_i;
        OFS_TAG_ID_SECOND: tag_id_second_final_part_next = wdata_i;
        OFS_TAG_ID_THIRD: tag_id_third_final_part_next = wdata_i;
        OFS_COLL_CTRL: collision_resolve_ctrl_next = wdata_i & COLL_CTRL_MASK;
        OFS_SENSE_RESP: sense_response_cfg_next = wdata_i & SENSE_RESP_MASK;
        OFS_EVENT_MASK: mask_next = wdata_i[EV_W-1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        OFS_RX_FRAME_CONFIG: rdata_next = rx_frame_config_reg;
        OFS_RX_FRAME_SIZE: rdata_next = {20'h0_0000, rx_frame_size_reg};
        OFS_TAG_ID_FINAL: rdata_next = tag_id_final_part_reg;
        OFS_TAG_ID_SECOND: rdata_next = tag_id_second_final_part_reg;
        OFS_TAG_ID_THIRD: rdata_next = tag_id_third_final_part_reg;
        OFS_COLL_CTRL: rdata_next = collision_resolve_ctrl_reg;
        OFS_SENSE_RESP: rdata_next = sense_response_cfg_reg;
        OFS_EVENT_STATUS: begin
          rdata_next = {27'h000_0000, status_reg};
          status_next = '0;
        end
        OFS_EVENT_MASK: rdata_next = {27'h000_0000, mask_reg};
        OFS_RX_RESULT: rdata_next = {30'h0000_0000, rx_result_reg};
        default: rdata_next = '0;
      endcase
    end
    // an event in the clearing read's cycle survives: set wins
    status_next = status_next | ev_set | frame_ev;
    if (frame_end && !frame_invalid) begin
      rx_frame_size_next = {byte_cnt_reg, bit_cnt_reg};
      rx_result_next = {par_bad_reg, crc_on && crc_good};
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_frame_config_reg <= RST_RX_FRAME_CONFIG;
      rx_frame_size_reg <= '0;
      tag_id_final_part_reg <= RST_TAG_ID_FINAL;
      tag_id_second_final_part_reg <= RST_TAG_ID_OTHER;
      tag_id_third_final_part_reg <= RST_TAG_ID_OTHER;
      collision_resolve_ctrl_reg <= RST_COLL_CTRL;
      sense_response_cfg_reg <= RST_SENSE_RESP;
      status_reg <= '0;
      mask_reg <= '0;
      rx_result_reg <= '0;
      rdata_reg <= '0;
    end else if (ce_i) begin
      rx_frame_config_reg <= rx_frame_config_next;
      rx_frame_size_reg <= rx_frame_size_next;
      tag_id_final_part_reg <= tag_id_final_part_next;
      tag_id_second_final_part_reg <= tag_id_second_final_part_next;
      tag_id_third_final_part_reg <= tag_id_third_final_part_next;
      collision_resolve_ctrl_reg <= collision_resolve_ctrl_next;
      sense_response_cfg_reg <= sense_response_cfg_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rx_result_reg <= rx_result_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = |(status_reg & mask_reg);
  assign coll_ctrl_o = collision_resolve_ctrl_reg[1:0];
  // byte 1 = {size, reserved, pattern}, byte 2 = {reserved nibble, platform}
  assign sense_res_o = sense_response_cfg_reg[15:0];

  // ---------------- anticollision level data ----------------
  nfrx_idlen_e id_len;
  nfrx_level_s level_reg, level_next;
  assign id_len = nfrx_idlen_e'(sense_response_cfg_reg[SR_IDLEN_LSB +: 2]);

  // byte [31:24] goes out first; the final part always closes the identifier
  always_comb begin
    level_next = '0;
    unique case (id_len)
      NFRX_ID_LEN_FOUR: begin
        if (ac_level_i == 2'h0) begin
          level_next.valid = 1'b1;
          level_next.final_level = 1'b1;
          level_next.data = tag_id_final_part_reg;
        end
      end
      NFRX_ID_LEN_SEVEN: begin
        if (ac_level_i == 2'h0) begin
          level_next.valid = 1'b1;
          level_next.data = {CASCADE_TAG, tag_id_second_final_part_reg[23:0]};
        end else if (ac_level_i == 2'h1) begin
          level_next.valid = 1'b1;
          level_next.final_level = 1'b1;
          level_next.data = tag_id_final_part_reg;
        end
      end
      NFRX_ID_LEN_TEN: begin
        if (ac_level_i == 2'h0) begin
          level_next.valid = 1'b1;
          level_next.data = {CASCADE_TAG, tag_id_third_final_part_reg[23:0]};
        end else if (ac_level_i == 2'h1) begin
          level_next.valid = 1'b1;
          level_next.data = {CASCADE_TAG, tag_id_second_final_part_reg[23:0]};
        end else if (ac_level_i == 2'h2) begin
          level_next.valid = 1'b1;
          level_next.final_level = 1'b1;
          level_next.data = tag_id_final_part_reg;
        end
      end
      default: level_next = '0;
    endcase
    level_next.check = xor4(level_next.data);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      level_reg <= '0;
    end else if (ce_i) begin
      level_reg <= level_next;
    end
  end
  assign ac_level_o = level_reg;

  // ---------------- assertions ----------------
  a_parity_skipped: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_reg == NFRX_BITS && par_wait_reg && rx_sym_i.valid &&
    rx_sym_i.kind == NFRX_SYM_DATA |=> bit_cnt_reg == $past(bit_cnt_reg) && !par_wait_reg)
    else $error("parity bit was counted as data");
  a_no_parity_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !parity_on && !$past(parity_on) |-> !par_wait_reg || $past(par_wait_reg))
    else $error("parity expected while disabled");
  a_start_required: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && sof_on && state_reg == NFRX_IDLE && rx_sym_i.valid &&
    rx_sym_i.kind == NFRX_SYM_DATA |=> state_reg == NFRX_IDLE && status_reg[EV_FRAMING_ERR])
    else $error("frame opened without start symbol");
  a_crc_result: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && frame_end && !frame_invalid |=>
    rx_result_reg[0] == ($past(crc_on) && $past(crc_reg) == 16'h0000 &&
    $past(byte_cnt_reg) >= 9'h2 && $past(bit_cnt_reg) == 3'h0))
    else $error("crc result not updated");
  a_size_report: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && frame_end && !frame_invalid |=>
    rx_frame_size_reg == {$past(byte_cnt_reg), $past(bit_cnt_reg)})
    else $error("frame size not reported");
  a_short_invalid: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && frame_end && byte_cnt_reg == 9'h0 && bit_cnt_reg < 3'h7 |=>
    status_reg[EV_INVALID] && $stable(rx_frame_size_reg))
    else $error("short frame accepted");
  a_final_part: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && level_next.final_level |=> ac_level_o.data == $past(tag_id_final_part_reg))
    else $error("final level not from final part");
  a_second_use: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && id_len == NFRX_ID_LEN_SEVEN && ac_level_i == 2'h0 |=>
    ac_level_o.data[31:24] == 8'h88 && !ac_level_o.final_level)
    else $error("double id first level wrong");
  a_third_use: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && id_len != NFRX_ID_LEN_TEN && ac_level_i == 2'h2 |=> !ac_level_o.valid)
    else $error("third level answered for short id");
  a_level_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && id_len == NFRX_ID_LEN_FOUR && ac_level_i != 2'h0 |=> !ac_level_o.valid)
    else $error("extra level for single id");
  a_pattern_field: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_i && addr_i == OFS_SENSE_RESP |=> sense_res_o[4:0] == $past(wdata_i[4:0]))
    else $error("pattern not placed in byte 1");
  a_platform_field: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && wr_i && addr_i == OFS_SENSE_RESP |=> sense_res_o[11:8] == $past(wdata_i[11:8]))
    else $error("platform nibble not placed in byte 2");

  c_good_frame: cover property (@(posedge clk_i) ce_i && frame_end && !frame_invalid && crc_good);
  c_parity_error: cover property (@(posedge clk_i) frame_ev[EV_PARITY_ERR]);
  c_triple_final: cover property (@(posedge clk_i) id_len == NFRX_ID_LEN_TEN && level_next.final_level);
  c_irq_raised: cover property (@(posedge clk_i) $rose(irq_o));
endmodule // nfrx_bank

// ---- bench/nfrx_reader_model.sv ----
// reader-side model: sends NFC-A receive symbols into the bank
`timescale 1ns/1ps
module nfrx_reader_model (
  input wire logic clk_i,
  output nfrx_pkg::nfrx_sym_s rx_sym_o
);
  import nfrx_pkg::*;
  initial rx_sym_o = '0;
  task automatic put(input nfrx_sym_e k, input logic b);
    @(posedge clk_i);
    rx_sym_o <= '{valid: 1'b1, kind: k, bit_val: b};
  endtask
  // bytes go out lsb first; bad_par flips the odd parity bit on purpose
  task automatic send(input logic [7:0] q[$], input logic [7:0] tail, input int nbits,
                      input logic sof, input logic par, input logic bad_par);
    if (sof) put(NFRX_SYM_START, 1'b0);
    foreach (q[i]) begin
      for (int j = 0; j < 8; j++) put(NFRX_SYM_DATA, q[i][j]);
      if (par) put(NFRX_SYM_DATA, ~^q[i] ^ bad_par);
    end
    for (int j = 0; j < nbits; j++) put(NFRX_SYM_DATA, tail[j]);
    put(NFRX_SYM_END, 1'b0);
    // an idle line shows the inverse, so a stale bit never looks valid
    @(posedge clk_i);
    rx_sym_o <= '{valid: 1'b0, kind: rx_sym_o.kind, bit_val: ~rx_sym_o.bit_val};
  endtask
endmodule // nfrx_reader_model

// ---- bench/nfrx_bank_tb.sv ----
// testbench: register access, frame reception, interrupt and anticollision answers
`timescale 1ns/1ps
module nfrx_bank_tb;
  import nfrx_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic [31:0] rdata_o;
  logic [31:0] rv;
  logic [1:0] ac_level_i = '0;
  logic [1:0] coll_ctrl_o;
  logic [15:0] sense_res_o;
  logic [15:0] c;
  logic irq_o;
  nfrx_sym_s rx_sym;
  nfrx_level_s ac_level_o;
  nfrx_level_s exp_lv;
  logic [7:0] fr[$];
  int err_count = 0;
  int num_checks = 0;

  nfrx_bank nfrx_bank_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_sym_i(rx_sym),
    .ac_level_i(ac_level_i), .ac_level_o(ac_level_o), .sense_res_o(sense_res_o),
    .coll_ctrl_o(coll_ctrl_o), .irq_o(irq_o));
  nfrx_reader_model nfrx_reader_model_i (.clk_i(clk_i), .rx_sym_o(rx_sym));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, rv, exp);
  endtask
  function automatic logic [15:0] crc_a(input logic [7:0] q[$]);
    logic [15:0] r;
    r = CRC_PRESET;
    foreach (q[i]) begin
      for (int j = 0; j < 8; j++) r = (r >> 1) ^ ((r[0] ^ q[i][j]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rchk("cfg_rst", OFS_RX_FRAME_CONFIG, 32'h0000_0015);
    rchk("size_rst", OFS_RX_FRAME_SIZE, 32'h0000_0000);
    rchk("final_rst", OFS_TAG_ID_FINAL, 32'h0000_6363);
    rchk("second_rst", OFS_TAG_ID_SECOND, 32'h0000_0000);
    rchk("third_rst", OFS_TAG_ID_THIRD, 32'h0000_0000);
    rchk("sense_rst", OFS_SENSE_RESP, 32'h0000_0001);
    rchk("unmapped", 12'h700, 32'h0000_0000);
    chk("sense_o_rst", sense_res_o, 16'h0001);
    $display("test reset done");
    wr(12'h700, 32'hFFFF_FFFF);
    rchk("unmapped_wr", 12'h700, 32'h0000_0000);
    wr(OFS_RX_FRAME_SIZE, 32'hFFFF_FFFF);
    rchk("size_ro", OFS_RX_FRAME_SIZE, 32'h0000_0000);
    wr(OFS_RX_FRAME_CONFIG, 32'hFFFF_FFFF);
    rchk("cfg_mask", OFS_RX_FRAME_CONFIG, 32'h0000_0015);
    wr(OFS_SENSE_RESP, 32'h0000_0A90);
    chk("sense_o", sense_res_o, 16'h0A90);
    rchk("sense_rd", OFS_SENSE_RESP, 32'h0000_0A90);
    wr(OFS_COLL_CTRL, 32'h0000_0003);
    chk("coll_o", coll_ctrl_o, 2'h3);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(OFS_COLL_CTRL, 32'h0000_0002);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rchk("coll_frozen", OFS_COLL_CTRL, 32'h0000_0003);
    $display("test registers done");
    wr(OFS_TAG_ID_FINAL, 32'hA1B2_C3D4);
    wr(OFS_TAG_ID_SECOND, 32'h0011_2233);
    wr(OFS_TAG_ID_THIRD, 32'h0044_5566);
    // length code 3 is not a legal size: no level may be answered
    for (int s = 0; s < 4; s++) begin
      wr(OFS_SENSE_RESP, (32'(s) << SR_IDLEN_LSB) | 32'h1);
      for (int l = 0; l < 3; l++) begin
        @(posedge clk_i);
        ac_level_i <= 2'(l);
        @(posedge clk_i);
        #1;
        exp_lv = '0;
        if (l <= s && s < 3) begin
          exp_lv.valid = 1'b1;
          exp_lv.final_level = (l == s);
          exp_lv.data = (l == s) ? 32'hA1B2_C3D4 :
                        {CASCADE_TAG, (s == 2 && l == 0) ? 24'h44_5566 : 24'h11_2233};
          exp_lv.check = exp_lv.data[31:24] ^ exp_lv.data[23:16] ^ exp_lv.data[15:8] ^
                         exp_lv.data[7:0];
        end
        chk("ac_level", ac_level_o, exp_lv);
      end
    end
    $display("test anticollision done");
    fr = '{8'h12, 8'h34};
    c = crc_a(fr);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    wr(OFS_RX_FRAME_CONFIG, 32'h0000_0015);
    nfrx_reader_model_i.send(fr, 8'h00, 0, 1'b1, 1'b1, 1'b0);
    rchk("size_crc", OFS_RX_FRAME_SIZE, 32'h0000_0020);
    rchk("crc_good", OFS_RX_RESULT, 32'h0000_0001);
    chk("irq_masked", irq_o, 1'b0);
    rchk("status_done", OFS_EVENT_STATUS, 32'h0000_0001);
    fr[3] = ~fr[3];
    nfrx_reader_model_i.send(fr, 8'h00, 0, 1'b1, 1'b1, 1'b0);
    rd(OFS_EVENT_STATUS);
    chk("crc_err", rv & 32'h2, 32'h2);
    rchk("crc_bad", OFS_RX_RESULT, 32'h0000_0000);
    nfrx_reader_model_i.send(fr, 8'h00, 0, 1'b1, 1'b1, 1'b1);
    rd(OFS_EVENT_STATUS);
    chk("par_err", rv & 32'h4, 32'h4);
    rd(OFS_RX_RESULT);
    chk("par_res", rv & 32'h2, 32'h2);
    $display("test crc and parity done");
    wr(OFS_RX_FRAME_CONFIG, 32'h0000_0000);
    wr(OFS_EVENT_MASK, 32'h0000_0001);
    fr = '{8'h12, 8'h34};
    nfrx_reader_model_i.send(fr, 8'h05, 3, 1'b0, 1'b0, 1'b0);
    rchk("size_plain", OFS_RX_FRAME_SIZE, 32'h0000_0013);
    chk("irq_on", irq_o, 1'b1);
    rchk("status_plain", OFS_EVENT_STATUS, 32'h0000_0001);
    @(posedge clk_i);
    #1 chk("irq_off", irq_o, 1'b0);
    fr = {};
    nfrx_reader_model_i.send(fr, 8'h15, 6, 1'b0, 1'b0, 1'b0);
    rd(OFS_EVENT_STATUS);
    chk("invalid", rv & 32'h8, 32'h8);
    rchk("size_kept", OFS_RX_FRAME_SIZE, 32'h0000_0013);
    nfrx_reader_model_i.send(fr, 8'h15, 7, 1'b0, 1'b0, 1'b0);
    rchk("size_seven", OFS_RX_FRAME_SIZE, 32'h0000_0007);
    wr(OFS_RX_FRAME_CONFIG, 32'h0000_0004);
    fr = '{8'hAA};
    nfrx_reader_model_i.send(fr, 8'h00, 0, 1'b0, 1'b0, 1'b0);
    rd(OFS_EVENT_STATUS);
    chk("no_start", rv & 32'h10, 32'h10);
    $display("test framing done");
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rchk("cfg_rst2", OFS_RX_FRAME_CONFIG, 32'h0000_0015);
    chk("coll_rst2", coll_ctrl_o, 2'h2);
    chk("irq_rst2", irq_o, 1'b0);
    rchk("size_rst2", OFS_RX_FRAME_SIZE, 32'h0000_0000);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // nfrx_bank_tb
